// File: src/pmia_pkg.sv
// shared constants, types and decode functions for the pmu interrupt aggregator
`default_nettype none
package pmia_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] STATUS_BASE = 8'h02;   // event_status_1 .. event_status_5
  localparam logic [7:0] MASK_BASE   = 8'h07;   // event_mask_1 .. event_mask_5
  localparam logic [7:0] NUM_BANKS   = 8'h05;
  localparam logic [7:0] FLAG_RESET  = 8'h00;   // status and mask value after reset
  localparam logic [7:0] READ_NONE   = 8'h00;   // unmapped addresses read as this

  // ---------------------------------------------------------------------------
  // serial bus
  // ---------------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR  = 7'h08;     // arbitrary value, no maker meaning
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;

  // ---------------------------------------------------------------------------
  // pin positions in the sampled pin vector
  // ---------------------------------------------------------------------------
  localparam int PIN_KEY   = 0;
  localparam int PIN_COUNT = 4;                 // key, wake a, wake b, wake c
  localparam int KEY_HELD_BIT = 7;              // bit of event_status_3

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned HOLD_TIME_MS    = 1000;
  localparam int unsigned HOLD_CYCLES_DEF = CLK_HZ / 1000 * HOLD_TIME_MS;
  localparam int          HOLD_CNT_W      = 25;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef logic [4:0][7:0] pmia_bank_t;
  localparam pmia_bank_t BANK_VALID = {8'hff, 8'hff, 8'hff, 8'hff, 8'hcf};

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ACK_ADDR = 3'b010,
    ST_WR       = 3'b011,
    ST_ACK_WR   = 3'b100,
    ST_RD       = 3'b101,
    ST_ACK_RD   = 3'b110
  } pmia_i2c_e;

  // one-cycle event pulses from the power modules
  typedef struct packed {
    logic [1:0] rtc;        // [1] second tick, [0] alarm match
    logic [1:0] usb;        // [1] supply falls, [0] supply rises
    logic [1:0] adapter;    // [1] sense falls, [0] sense rises
    logic [6:0] charger;    // event_status_3 bits 6..0
    logic [7:0] supply;     // event_status_4
    logic [7:0] regulator;  // event_status_5
  } pmia_src_s;

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  function automatic logic isStatus(input logic [7:0] a);
    isStatus = (a >= STATUS_BASE) && (a < STATUS_BASE + NUM_BANKS);
  endfunction

  function automatic logic isMask(input logic [7:0] a);
    isMask = (a >= MASK_BASE) && (a < MASK_BASE + NUM_BANKS);
  endfunction

  function automatic logic [2:0] bankIdx(input logic [7:0] a);
    logic [7:0] d;
    d = isStatus(a) ? (a - STATUS_BASE) : (a - MASK_BASE);
    bankIdx = d[2:0];
  endfunction

endpackage
`default_nettype wire

// File: src/pmia_sync.sv
// two-stage synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module pmia_sync #(
  parameter int               W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // levels
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// File: src/pmia_hold_timer.sv
// power key hold timer, one pulse per press held long enough
`timescale 1ns/10ps
`default_nettype none
module pmia_hold_timer import pmia_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // key level, already synchronised
  input  wire logic keyLow,
  output var  logic heldPulse
);

  localparam logic [HOLD_CNT_W-1:0] LAST = HOLD_CNT_W'(HOLD_CYCLES - 1);

  logic [HOLD_CNT_W-1:0] count_reg;
  logic [HOLD_CNT_W-1:0] count_next;
  logic                  fired_reg;
  logic                  fired_next;
  logic                  pulse_next;

  // count low cycles; fire once, rearm only on release so a long hold gives one flag
  always_comb begin
    count_next = count_reg;
    fired_next = fired_reg;
    pulse_next = 1'b0;
    if (!keyLow) begin
      count_next = '0;
      fired_next = 1'b0;
    end else if (!fired_reg) begin
      if (count_reg == LAST) begin
        pulse_next = 1'b1;
        fired_next = 1'b1;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= '0;
      fired_reg <= 1'b0;
      heldPulse <= 1'b0;
    end else begin
      count_reg <= count_next;
      fired_reg <= fired_next;
      heldPulse <= pulse_next;
    end
  end

endmodule
`default_nettype wire

// File: src/pmia_aggregator.sv
// pmu interrupt aggregator: event flags, masks, serial register access and request pin
`timescale 1ns/10ps
`default_nettype none
module pmia_aggregator import pmia_pkg::*; #(
  parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  // clock and unpowered-state reset
  input  wire logic      clk,
  input  wire logic      srst,
  // serial register bus pins
  input  wire logic      scl,
  input  wire logic      sdaIn,
  output var  logic      sdaOut,
  output var  logic      sdaOeN,
  // open-drain interrupt request pin
  output var  logic      irqOut,
  output var  logic      irqOeN,
  // key and wake pins
  input  wire logic      powerKey,
  input  wire logic      wakeInputA,
  input  wire logic      wakeInputB,
  input  wire logic      wakeInputC,
  // event pulses from the power modules
  input  wire pmia_src_s src
);

  // ---------------------------------------------------------------------------
  // pin synchronisation and edge detection
  // ---------------------------------------------------------------------------
  logic [1:0]           busS;
  logic [PIN_COUNT-1:0] pinS;
  logic                 sclS;
  logic                 sdaS;
  logic                 sclPrev_reg;
  logic                 sdaPrev_reg;
  logic [PIN_COUNT-1:0] pinPrev_reg;
  logic [2:0]           primed_reg;
  logic                 primed;
  logic                 sclRise;
  logic                 sclFall;
  logic                 startDet;
  logic                 stopDet;
  logic                 keyHeld;

  // bus lines idle high, so their synchroniser starts high to avoid a false start
  pmia_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({scl, sdaIn}),
    .q    (busS)
  );

  pmia_sync #(.W(PIN_COUNT), .INIT('0)) u_pin_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({wakeInputC, wakeInputB, wakeInputA, powerKey}),
    .q    (pinS)
  );

  pmia_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold (
    .clk       (clk),
    .srst      (srst),
    .keyLow    (primed & ~pinS[PIN_KEY]),
    .heldPulse (keyHeld)
  );

  assign sclS     = busS[1];
  assign sdaS     = busS[0];
  assign sclRise  = sclS & ~sclPrev_reg;
  assign sclFall  = ~sclS & sclPrev_reg;
  assign startDet = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  assign stopDet  = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;
  assign primed   = primed_reg[2];

  // previous levels; edges wait three cycles for the pin synchroniser to hold real levels,
  // since it starts low and a pin idling high would otherwise log a false rise
  always_ff @(posedge clk) begin
    if (srst) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      pinPrev_reg <= '0;
      primed_reg  <= 3'h0;
    end else begin
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
      pinPrev_reg <= pinS;
      primed_reg  <= {primed_reg[1:0], 1'b1};
    end
  end

  // ---------------------------------------------------------------------------
  // event vector, one byte per status register
  // ---------------------------------------------------------------------------
  pmia_bank_t ev;
  logic [7:0] edgeByte;

  // key edges in bits 1:0, then rise/fall pairs for wake a, b, c
  always_comb begin
    edgeByte = 8'h00;
    for (int p = 0; p < PIN_COUNT; p++) begin
      edgeByte[2*p]   = primed & pinS[p] & ~pinPrev_reg[p];
      edgeByte[2*p+1] = primed & ~pinS[p] & pinPrev_reg[p];
    end
  end

  assign ev[0] = {src.rtc, 2'b00, src.usb, src.adapter} & BANK_VALID[0];
  assign ev[1] = edgeByte;
  assign ev[2] = {keyHeld, src.charger};
  assign ev[3] = src.supply;
  assign ev[4] = src.regulator;

  // ---------------------------------------------------------------------------
  // serial slave state machine
  // ---------------------------------------------------------------------------
  pmia_i2c_e  st_reg;
  pmia_i2c_e  st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic       ptrPend_reg;
  logic       ptrPend_next;
  logic       rnw_reg;
  logic       rnw_next;
  logic       ackOk_reg;
  logic       ackOk_next;
  logic       sdaLow_reg;
  logic       sdaLow_next;
  logic       loadRead;
  logic       wrStrobe;
  logic [7:0] rdByte;
  pmia_bank_t status_reg;
  pmia_bank_t status_next;
  pmia_bank_t mask_reg;
  pmia_bank_t mask_next;

  function automatic logic [7:0] regRead(input logic [7:0] a, input pmia_bank_t st, input pmia_bank_t mk);
    regRead = READ_NONE;
    if (isStatus(a)) begin
      regRead = st[bankIdx(a)];
    end else if (isMask(a)) begin
      regRead = mk[bankIdx(a)];
    end
  endfunction

  assign rdByte = regRead(ptr_reg, status_reg, mask_reg);

  // bits move on scl fall and are sampled on scl rise; start and stop win over all
  always_comb begin
    st_next      = st_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    ptr_next     = ptr_reg;
    ptrPend_next = ptrPend_reg;
    rnw_next     = rnw_reg;
    ackOk_next   = ackOk_reg;
    sdaLow_next  = sdaLow_reg;
    loadRead     = 1'b0;
    wrStrobe     = 1'b0;
    if (stopDet) begin
      st_next     = ST_IDLE;
      sdaLow_next = 1'b0;
    end else if (startDet) begin
      st_next     = ST_ADDR;
      cnt_next    = 4'h0;
      sdaLow_next = 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (sclRise) begin
            shift_next = {shift_reg[6:0], sdaS};
            cnt_next   = cnt_reg + 4'h1;
          end else if (sclFall && cnt_reg == BYTE_BITS) begin
            if (shift_reg[7:1] == DEV_ADDR) begin
              rnw_next    = shift_reg[0];
              sdaLow_next = 1'b1;
              st_next     = ST_ACK_ADDR;
            end else begin
              st_next = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (sclFall) begin
            cnt_next = 4'h0;
            if (rnw_reg) begin
              loadRead = 1'b1;
            end else begin
              sdaLow_next  = 1'b0;
              ptrPend_next = 1'b1;
              st_next      = ST_WR;
            end
          end
        end
        ST_WR: begin
          if (sclRise) begin
            shift_next = {shift_reg[6:0], sdaS};
            cnt_next   = cnt_reg + 4'h1;
          end else if (sclFall && cnt_reg == BYTE_BITS) begin
            sdaLow_next = 1'b1;
            st_next     = ST_ACK_WR;
            if (ptrPend_reg) begin
              ptr_next     = shift_reg;
              ptrPend_next = 1'b0;
            end else begin
              wrStrobe = 1'b1;
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end
        ST_ACK_WR: begin
          if (sclFall) begin
            sdaLow_next = 1'b0;
            cnt_next    = 4'h0;
            st_next     = ST_WR;
          end
        end
        ST_RD: begin
          if (sclFall) begin
            if (cnt_reg == LAST_BIT) begin
              sdaLow_next = 1'b0;
              st_next     = ST_ACK_RD;
            end else begin
              shift_next  = {shift_reg[6:0], 1'b0};
              sdaLow_next = ~shift_reg[6];
              cnt_next    = cnt_reg + 4'h1;
            end
          end
        end
        ST_ACK_RD: begin
          if (sclRise) begin
            ackOk_next = ~sdaS;
          end else if (sclFall) begin
            cnt_next = 4'h0;
            if (ackOk_reg) begin
              loadRead = 1'b1;
            end else begin
              st_next = ST_IDLE;
            end
          end
        end
        default: begin
          st_next     = ST_IDLE;
          sdaLow_next = 1'b0;
        end
      endcase
      // a burst read moves on to the next register with no new pointer
      if (loadRead) begin
        shift_next  = rdByte;
        sdaLow_next = ~rdByte[7];
        ptr_next    = ptr_reg + 8'h01;
        st_next     = ST_RD;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg      <= ST_IDLE;
      cnt_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      ptrPend_reg <= 1'b0;
      rnw_reg     <= 1'b0;
      ackOk_reg   <= 1'b0;
      sdaLow_reg  <= 1'b0;
    end else begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      ptr_reg     <= ptr_next;
      ptrPend_reg <= ptrPend_next;
      rnw_reg     <= rnw_next;
      ackOk_reg   <= ackOk_next;
      sdaLow_reg  <= sdaLow_next;
    end
  end

  // ---------------------------------------------------------------------------
  // flags and masks
  // ---------------------------------------------------------------------------
  pmia_bank_t clr;
  pmia_bank_t clrNoEv_reg;
  logic       irqLow_reg;
  logic [7:0] pendAfter;

  // clear exactly what the read returned; a same-cycle event sets again and wins
  always_comb begin
    status_next = status_reg;
    mask_next   = mask_reg;
    clr         = '0;
    for (int b = 0; b < 5; b++) begin
      if (loadRead && isStatus(ptr_reg) && bankIdx(ptr_reg) == 3'(b)) begin
        clr[b] = status_reg[b];
      end
      status_next[b] = ((status_reg[b] & ~clr[b]) | ev[b]) & BANK_VALID[b];
      if (wrStrobe && isMask(ptr_reg) && bankIdx(ptr_reg) == 3'(b)) begin
        mask_next[b] = shift_reg & BANK_VALID[b];
      end
    end
  end

  // request pin: all unmasked flags count alike, nothing ordered here
  always_comb begin
    pendAfter = 8'h00;
    for (int b = 0; b < 5; b++) begin
      pendAfter = pendAfter | (status_next[b] & ~mask_next[b]);
    end
  end

  // the unpowered reset empties all flags and masks; a read clears only the flags it returns
  always_ff @(posedge clk) begin
    if (srst) begin
      status_reg  <= {5{FLAG_RESET}};
      mask_reg    <= {5{FLAG_RESET}};
      irqLow_reg  <= 1'b0;
      clrNoEv_reg <= '0;
    end else begin
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      irqLow_reg  <= |pendAfter;
      clrNoEv_reg <= clr & ~ev;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOeN = ~sdaLow_reg;
  assign irqOut = 1'b0;
  assign irqOeN = ~irqLow_reg;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic [7:0] pendNow;
  always_comb begin
    pendNow = 8'h00;
    for (int b = 0; b < 5; b++) begin
      pendNow = pendNow | (status_reg[b] & ~mask_reg[b]);
    end
  end

  irq_follows_a: assert property ((pendNow != 8'h00) |-> !irqOeN)
    else $error("request pin released with an unmasked flag pending");
  masked_quiet_a: assert property ((pendNow == 8'h00) |-> irqOeN)
    else $error("request pin driven with no unmasked flag");
  key_held_a: assert property (keyHeld |-> (!$past(pinS[PIN_KEY]) && !$past(pinS[PIN_KEY], 2)))
    else $error("hold flag without the key held low");
  held_flag_a: assert property (keyHeld |=> status_reg[2][KEY_HELD_BIT])
    else $error("hold pulse did not set its flag");
  reserved_zero_a: assert property ((status_reg[0][5:4] == 2'b00) && (mask_reg[0][5:4] == 2'b00))
    else $error("reserved bits of bank one are set");
  read_clears_a: assert property ((status_reg[0] & clrNoEv_reg[0]) == 8'h00
                                  && (status_reg[4] & clrNoEv_reg[4]) == 8'h00)
    else $error("flag returned by a read was not cleared");
  event_kept_a: assert property ((ev[1] != 8'h00) |=> ((status_reg[1] & $past(ev[1])) == $past(ev[1])))
    else $error("edge event lost");
  irq_release_a: assert property ((loadRead && pendAfter == 8'h00 && !irqOeN) |=> irqOeN)
    else $error("request pin not released after clearing read");
  mask_write_a: assert property ((wrStrobe && isMask(ptr_reg)) |=>
                                 mask_reg[bankIdx($past(ptr_reg))] == ($past(shift_reg) & BANK_VALID[bankIdx($past(ptr_reg))]))
    else $error("mask write did not land");
  ack_drive_a: assert property ((st_reg == ST_ACK_ADDR) |-> !sdaOeN)
    else $error("address not acknowledged");

endmodule
`default_nettype wire

// File: dv/pmia_host_model.sv
// bus host model that writes and burst-reads the aggregator registers
`timescale 1ns/10ps
`default_nettype none
module pmia_host_model import pmia_pkg::*; (
  // clock
  input  wire logic clk,
  // bus pins, sda is the resolved wire level
  input  wire logic sda,
  output var  logic scl,
  output var  logic sdaLow
);
  // ---------------------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------------------
  logic [7:0] rx;
  logic [7:0] got [10];

  // released bus at time zero
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // half bus period; 10 clk keeps every phase above the 8 clk floor
  task automatic hp();
    repeat (10) @(posedge clk);
  endtask

  // one bit out and one sampled; sda moves 4 clk after scl falls so it never mimics a start
  task automatic bitIo(input logic b);
    sdaLow <= ~b;
    hp();
    scl <= 1'b1;
    hp();
    rx = {rx[6:0], sda};
    scl <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // start or repeated start: release sda first, then raise scl, then pull sda
  task automatic start();
    sdaLow <= 1'b0;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    hp();
    sdaLow <= 1'b1;
    hp();
    scl <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic stop();
    sdaLow <= 1'b1;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    hp();
    sdaLow <= 1'b0;
    hp();
  endtask

  // byte out, msb first, then the acknowledge slot left released
  task automatic sendB(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bitIo(b[i]);
    bitIo(1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    sendB({DEV_ADDR, 1'b0});
    sendB(a);
    sendB(d);
    stop();
  endtask

  // pointer, repeated start, burst of n bytes in rising register order; the host alone picks the length
  task automatic rd(input logic [7:0] a, input int n);
    start();
    sendB({DEV_ADDR, 1'b0});
    sendB(a);
    start();
    sendB({DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      for (int j = 0; j < 8; j++) bitIo(1'b1);
      got[i] = rx;
      bitIo(i == n - 1);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// File: dv/pmu_interrupt_aggregator_bench.sv
// self-checking bench for the pmu interrupt aggregator
`timescale 1ns/10ps
`default_nettype none
module pmu_interrupt_aggregator_bench import pmia_pkg::*;;
  // ---------------------------------------------------------------------------
  // harness
  // ---------------------------------------------------------------------------
  localparam int unsigned HOLD = 20;  // short key hold keeps the run small
  logic      clk = 1'b0;
  logic      srst = 1'b1;
  logic      powerKey = 1'b1;
  logic [2:0] wake = 3'h0;
  pmia_src_s src = '0;
  logic      scl;
  logic      hostLow;
  logic      sdaOut;
  logic      sdaOeN;
  logic      irqOut;
  logic      irqOeN;
  int        fails = 0;
  int        nCompared = 0;
  // open-drain wires with pull-ups
  wire logic sda = !sdaOeN ? sdaOut : (hostLow ? 1'b0 : 1'b1);
  wire logic irqPin = !irqOeN ? irqOut : 1'b1;

  always #20 clk = ~clk;

  pmia_aggregator #(.HOLD_CYCLES(HOLD)) u_dut (
    .clk(clk), .srst(srst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .irqOut(irqOut), .irqOeN(irqOeN), .powerKey(powerKey), .wakeInputA(wake[0]),
    .wakeInputB(wake[1]), .wakeInputC(wake[2]), .src(src)
  );
  pmia_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sdaLow(hostLow));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic chkIrq(input logic exp);
    chk({7'h00, irqPin}, {7'h00, exp});
  endtask

  // burst read; expected bytes packed with the last byte at the bottom
  task automatic rdChk(input logic [7:0] a, input int n, input logic [39:0] e);
    u_host.rd(a, n);
    for (int i = 0; i < n; i++) chk(u_host.got[i], e[8 * (n - 1 - i) +: 8]);
  endtask

  // one-cycle pulse on the event inputs, then time for the request to settle
  task automatic fire(input pmia_src_s s);
    src <= s;
    cyc(1);
    src <= '0;
    cyc(4);
  endtask

  // flag a pattern, see the request, read it all and see it gone
  task automatic round(input pmia_src_s s, input logic [39:0] e);
    fire(s);
    chkIrq(1'b0);
    rdChk(8'h02, 5, e);
    chkIrq(1'b1);
    rdChk(8'h02, 5, 40'h0);
  endtask

  task automatic stopTest();
    $display("compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    cyc(6);
    srst <= 1'b0;
    cyc(8);
    // a key already high at release must not log a rise
    u_host.rd(8'h02, 10);
    for (int i = 0; i < 10; i++) chk(u_host.got[i], 8'h00);
    chkIrq(1'b1);
    round({2'b01, 2'b10, 2'b01, 7'h55, 8'ha5, 8'h3c}, 40'h490055a53c);
    round({2'b10, 2'b01, 2'b10, 7'h2a, 8'h5a, 8'hc3}, 40'h86002a5ac3);
    // each wake pin toggles, then a long and a too-short key press
    for (int i = 0; i < 3; i++) begin
      wake[i] <= 1'b1;
      cyc(10);
      wake[i] <= 1'b0;
      cyc(10);
    end
    powerKey <= 1'b0;
    cyc(HOLD + 12);
    powerKey <= 1'b1;
    cyc(10);
    rdChk(8'h03, 2, 40'hff80);
    powerKey <= 1'b0;
    cyc(HOLD - 6);
    powerKey <= 1'b1;
    cyc(10);
    rdChk(8'h03, 2, 40'h0300);
    // masked events still flag but keep the request quiet
    for (int i = 7; i < 12; i++) u_host.wr(8'(i), 8'hff);
    rdChk(8'h07, 5, 40'hcfffffffff);
    fire('1);
    chkIrq(1'b1);
    u_host.wr(8'h07, 8'h00);
    chkIrq(1'b0);
    rdChk(8'h02, 5, 40'hcf007fffff);
    chkIrq(1'b1);
    for (int i = 7; i < 12; i++) u_host.wr(8'(i), 8'h00);
    // status and unmapped places ignore writes
    u_host.wr(8'h02, 8'hff);
    u_host.wr(8'h0c, 8'hff);
    rdChk(8'h0c, 1, 40'h00);
    rdChk(8'h02, 1, 40'h00);
    // an event held on through a read-and-clear survives it
    src.supply <= 8'h01;
    rdChk(8'h05, 1, 40'h01);
    src <= '0;
    cyc(2);
    rdChk(8'h05, 1, 40'h01);
    rdChk(8'h05, 1, 40'h00);
    // pending flags are also emptied by the unpowered reset
    fire({2'b11, 2'b00, 2'b00, 7'h00, 8'h00, 8'h00});
    chkIrq(1'b0);
    srst <= 1'b1;
    cyc(6);
    srst <= 1'b0;
    cyc(8);
    chkIrq(1'b1);
    rdChk(8'h02, 5, 40'h0);
    stopTest();
  end

  // watchdog, about two and a half times the expected run length
  initial begin
    cyc(80000);
    fails++;
    stopTest();
  end
endmodule
`default_nettype wire
